// ### src/popt_regs.vh
// Object indices, field positions, codes and reset values of the
// positioning option and I/O map block.
// Assumes the includer is a single 125 MHz clock domain.
`ifndef POPT_REGS_VH
`define POPT_REGS_VH

// Object indices.
`define POPT_OBJ_CONTROL      16'h6040
`define POPT_OBJ_STATUS       16'h6041
`define POPT_OBJ_TARGET       16'h607A
`define POPT_OBJ_OPTION       16'h60F2
`define POPT_OBJ_FOLLOW_ERR   16'h60F4
`define POPT_OBJ_DIG_IN       16'h60FD
`define POPT_OBJ_DIG_OUT      16'h60FE

// Subindices.
`define POPT_SUB_ZERO         8'h00
`define POPT_SUB_FIRST        8'h01
`define POPT_DOUT_HIGHEST     32'h0000_0001

// Reset values.
`define POPT_OPTION_RESET     16'h0001
`define POPT_DOUT_RESET       32'h0000_0001
`define POPT_ZERO32           32'h0000_0000
`define POPT_ZERO16           16'h0000

// Positioning option word fields.
`define POPT_REL_LSB          0
`define POPT_REL_MSB          1
`define POPT_AUTOCLR_LSB      4
`define POPT_AUTOCLR_MSB      5
`define POPT_ROT_LSB          6
`define POPT_ROT_MSB          7
`define POPT_INTERP_LSB       8
`define POPT_INTERP_MSB       11
`define POPT_TOP_BIT          15
`define POPT_OPTION_MASK      16'h8FF3

// Control and status bits.
`define POPT_CTL_NEW_SETPOINT 5
`define POPT_CTL_RELATIVE     6
`define POPT_STS_REACHED      10
`define POPT_STS_SETPOINT_ACK 12

// Digital input word positions.
`define POPT_DIN_NEG_END      0
`define POPT_DIN_POS_END      1
`define POPT_DIN_HOMING       2
`define POPT_DIN_GENERAL_LSB  16

// Two-bit option codes.
`define POPT_CODE_00          2'h0
`define POPT_CODE_01          2'h1
`define POPT_CODE_10          2'h2
`define POPT_CODE_11          2'h3

`endif

// ### src/popt_positioning_io.v
// Positioning option decoder with control/status handshake, following
// error, digital input and digital output objects.
// Assumes a master that reaches objects by index and subindex through a
// one-request-at-a-time port, and a trajectory generator on the same clock.
// Positions and range limits are used as given, with no range check.
//
// How it works
// (RULE_01) Only the defined option fields are stored; other bits read zero.
// (RULE_02) The relative reference applies only when control bit 6 is set.
// (RULE_03) Relative code 00 adds to the last target, 01 ramp, 10 actual.
// (RULE_04) Autoclear code 01 or 10 lets the device clear new-setpoint bit 5.
// (RULE_05) After the device clears bit 5 it also clears acknowledge bit 12.
// (RULE_06) The device writes the control word, so a read-back may differ.
// (RULE_07) Autoclear code 01 clears bit 5 once the running move is at target.
// (RULE_08) Code 10 clears bit 5 at once; code 00 keeps the master handshake.
// (RULE_09) Rotary code 00 moves like a linear axis and wraps at the limits.
// (RULE_10) Rotary code 01 moves only negative, via the minimum limit if above.
// (RULE_11) Rotary code 10 moves only positive, via the maximum limit if below.
// (RULE_12) Rotary code 11 takes the shortest way, positive under half a turn.
// (RULE_13) The following error is a signed 32-bit read-only object.
// (RULE_14) The digital input word is read-only and zero from reset.
// (RULE_15) Inputs: negative end bit 0, positive 1, homing 2, general from 16.
// (RULE_16) A writable 32-bit digital output word drives the motor outputs.
// (RULE_17) Reserved option codes behave as code 00.
`timescale 1ns/1ps
`include "popt_regs.vh"

module popt_positioning_io
#(
  parameter GEN_INPUTS = 8
)
(
  input  wire                  i_clk,
  input  wire                  i_reset,
  input  wire                  i_obj_read,
  input  wire                  i_obj_write,
  input  wire [15:0]           i_obj_index,
  input  wire [7:0]            i_obj_subindex,
  input  wire [31:0]           i_obj_wdata,
  output reg  [31:0]           o_obj_rdata,
  output reg                   o_obj_ack,
  output reg                   o_obj_error,
  input  wire [31:0]           i_following_error,
  input  wire [31:0]           i_ramp_position,
  input  wire [31:0]           i_actual_position,
  input  wire [31:0]           i_range_min,
  input  wire [31:0]           i_range_max,
  input  wire                  i_target_reached,
  input  wire                  i_negative_end_switch,
  input  wire                  i_positive_end_switch,
  input  wire                  i_homing_switch,
  input  wire [GEN_INPUTS-1:0] i_general_in,
  output reg  [31:0]           o_abs_target,
  output reg                   o_setpoint_strobe,
  output reg                   o_move_negative,
  output reg                   o_via_limit,
  output reg                   o_wrap_enable,
  output reg  [31:0]           o_digital_out
);

  // Three switch pins sit below the general inputs.
  localparam NPIN = GEN_INPUTS + 3;

  // Object storage.
  reg  [15:0] control;
  reg  [15:0] option_word;
  reg  [31:0] target;
  reg         setpoint_ack;
  reg         move_pending;
  reg         prev_new_setpoint;
  reg  [31:0] digital_in;

  // Pin synchronisers: three stages, a change counts once stages 2 and 3
  // agree, so a single-cycle glitch at stage 2 never reaches the word.
  // Reset clears every stage, so the input word reads zero from start-up.
  reg  [NPIN-1:0] pin_s1;
  reg  [NPIN-1:0] pin_s2;
  reg  [NPIN-1:0] pin_s3;
  reg  [NPIN-1:0] pin_stable;
  wire [NPIN-1:0] pins_raw;

  assign pins_raw = {i_general_in, i_homing_switch,
                     i_positive_end_switch, i_negative_end_switch};

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pin_s1 <= {NPIN{1'b0}};
      pin_s2 <= {NPIN{1'b0}};
      pin_s3 <= {NPIN{1'b0}};
    end
    else
    begin
      pin_s1 <= pins_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Per-pin acceptance filter.
  // A pin that keeps toggling holds its last agreed level.
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1)
    begin : g_pin
      always @(posedge i_clk)
      begin
        if (i_reset)
          pin_stable[g] <= 1'b0;
        else if (pin_s2[g] == pin_s3[g])
          pin_stable[g] <= pin_s3[g];
      end
    end
  endgenerate

  // Input word assembly; unused general bits stay zero.
  // It reaches the bus only through the registered read data.
  always @*
  begin
    digital_in = `POPT_ZERO32;
    digital_in[`POPT_DIN_NEG_END] = pin_stable[0]; // [RULE_15]
    digital_in[`POPT_DIN_POS_END] = pin_stable[1]; // [RULE_15]
    digital_in[`POPT_DIN_HOMING]  = pin_stable[2]; // [RULE_15]
    digital_in[`POPT_DIN_GENERAL_LSB +: GEN_INPUTS] =
      pin_stable[NPIN-1:3]; // [RULE_15]
  end

  // Option field decode; reserved codes fold to code 00.
  // Rotary code 11 is a real mode, so only the other two fields fold.
  wire [1:0] rel_raw  = option_word[`POPT_REL_MSB:`POPT_REL_LSB];
  wire [1:0] clr_raw  = option_word[`POPT_AUTOCLR_MSB:`POPT_AUTOCLR_LSB];
  wire [1:0] relative_reference_select =
    (rel_raw == `POPT_CODE_11) ? `POPT_CODE_00 : rel_raw; // [RULE_17]
  wire [1:0] setpoint_autoclear_select =
    (clr_raw == `POPT_CODE_11) ? `POPT_CODE_00 : clr_raw; // [RULE_17]
  wire [1:0] rotary_direction_select =
    option_word[`POPT_ROT_MSB:`POPT_ROT_LSB];

  wire new_setpoint = control[`POPT_CTL_NEW_SETPOINT];
  wire take_setpoint = new_setpoint && !prev_new_setpoint;

  // Absolute target of a new setpoint.
  // Relative sums wrap around; an overflow is not flagged.
  reg [31:0] rel_base;
  reg [31:0] next_abs_target;
  always @*
  begin
    case (relative_reference_select)
      `POPT_CODE_01: rel_base = i_ramp_position;   // [RULE_03]
      `POPT_CODE_10: rel_base = i_actual_position; // [RULE_03]
      default:       rel_base = o_abs_target;      // [RULE_03]
    endcase
    if (control[`POPT_CTL_RELATIVE]) // [RULE_02]
      next_abs_target = rel_base + target;
    else
      next_abs_target = target;
  end

  // Direction choice. Half a turn is half the position range span.
  // The outputs are latched only with a setpoint, so an option write
  // during a move never turns the running move around.
  // Positions outside the range are not folded back into it.
  wire [31:0] span      = i_range_max - i_range_min;
  wire [31:0] half_turn = {1'b0, span[31:1]};
  wire [31:0] fwd_dist  = next_abs_target - i_actual_position;
  wire        tgt_above = $signed(next_abs_target) >
                          $signed(i_actual_position);
  wire        tgt_below = $signed(next_abs_target) <
                          $signed(i_actual_position);
  wire [31:0] fwd_wrapped = tgt_below ? fwd_dist + span : fwd_dist;

  reg next_negative;
  reg next_via_limit;
  reg next_wrap;
  always @*
  begin
    next_negative  = 1'b0;
    next_via_limit = 1'b0;
    next_wrap      = 1'b0;
    case (rotary_direction_select)
      `POPT_CODE_01:
      begin
        next_negative  = 1'b1;      // [RULE_10]
        next_via_limit = tgt_above; // [RULE_10]
      end
      `POPT_CODE_10:
      begin
        next_via_limit = tgt_below; // [RULE_11]
      end
      `POPT_CODE_11:
      begin
        // Ties at exactly half a turn go negative.
        // The distance wraps by the span when the target lies below.
        next_negative  = !(fwd_wrapped < half_turn); // [RULE_12]
        next_via_limit = next_negative ? tgt_above : tgt_below; // [RULE_12]
      end
      default:
      begin
        next_negative = tgt_below;
        next_wrap     = 1'b1; // [RULE_09]
      end
    endcase
  end

  // Device-side release of the new-setpoint bit.
  // Code 01 trusts i_target_reached to fall once a new move starts; a
  // generator that holds it high past the strobe releases bit 5 early.
  wire auto_release = new_setpoint && setpoint_ack &&
    ((setpoint_autoclear_select == `POPT_CODE_10) || // [RULE_08]
     (setpoint_autoclear_select == `POPT_CODE_01 &&
      move_pending && i_target_reached)); // [RULE_07]

  wire wr_ctl = i_obj_write && i_obj_index == `POPT_OBJ_CONTROL &&
                i_obj_subindex == `POPT_SUB_ZERO;

  // Control word, setpoint handshake and move tracking. A master write in
  // the cycle of an automatic release wins, so a fresh request is kept.
  // The acknowledge falls one cycle after bit 5 falls, whoever clears it.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      control           <= `POPT_ZERO16;
      prev_new_setpoint <= 1'b0;
      setpoint_ack      <= 1'b0;
      move_pending      <= 1'b0;
      o_abs_target      <= `POPT_ZERO32;
      o_setpoint_strobe <= 1'b0;
      o_move_negative   <= 1'b0;
      o_via_limit       <= 1'b0;
      o_wrap_enable     <= 1'b1;
    end
    else
    begin
      prev_new_setpoint <= new_setpoint;
      o_setpoint_strobe <= take_setpoint;
      if (wr_ctl)
        control <= i_obj_wdata[15:0];
      else if (auto_release)
        control[`POPT_CTL_NEW_SETPOINT] <= 1'b0; // [RULE_04] [RULE_06]
      if (take_setpoint)
      begin
        setpoint_ack    <= 1'b1;
        move_pending    <= 1'b1;
        o_abs_target    <= next_abs_target;
        o_move_negative <= next_negative;
        o_via_limit     <= next_via_limit;
        o_wrap_enable   <= next_wrap;
      end
      else
      begin
        if (!new_setpoint)
          setpoint_ack <= 1'b0; // [RULE_05]
        if (move_pending && i_target_reached)
          move_pending <= 1'b0;
      end
    end
  end

  // Object read multiplexer.
  // Reads are registered, so every output comes from a flip-flop at the
  // cost of one cycle of latency.
  reg [31:0] read_value;
  reg        read_hit;
  always @*
  begin
    read_value = `POPT_ZERO32;
    read_hit   = (i_obj_subindex == `POPT_SUB_ZERO);
    case (i_obj_index)
      `POPT_OBJ_CONTROL:    read_value = {16'h0000, control}; // [RULE_06]
      `POPT_OBJ_STATUS:
      begin
        read_value[`POPT_STS_REACHED]      = i_target_reached;
        read_value[`POPT_STS_SETPOINT_ACK] = setpoint_ack;
      end
      `POPT_OBJ_TARGET:     read_value = target;
      `POPT_OBJ_OPTION:     read_value = {16'h0000, option_word};
      `POPT_OBJ_FOLLOW_ERR: read_value = i_following_error; // [RULE_13]
      `POPT_OBJ_DIG_IN:     read_value = digital_in;        // [RULE_14]
      `POPT_OBJ_DIG_OUT:
      begin
        if (i_obj_subindex == `POPT_SUB_FIRST)
        begin
          read_value = o_digital_out;
          read_hit   = 1'b1;
        end
        else
          read_value = `POPT_DOUT_HIGHEST;
      end
      default:              read_hit = 1'b0;
    endcase
  end

  // Write acceptance: read-only objects and unknown entries are refused.
  reg write_ok;
  always @*
  begin
    case (i_obj_index)
      `POPT_OBJ_CONTROL,
      `POPT_OBJ_TARGET,
      `POPT_OBJ_OPTION: write_ok = (i_obj_subindex == `POPT_SUB_ZERO);
      `POPT_OBJ_DIG_OUT: write_ok = (i_obj_subindex == `POPT_SUB_FIRST);
      default:          write_ok = 1'b0; // [RULE_13] [RULE_14]
    endcase
  end

  // Object storage writes and the one-cycle answer.
  // A refused write still answers, with the error flag, and stores nothing.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      option_word   <= `POPT_OPTION_RESET;
      target        <= `POPT_ZERO32;
      o_digital_out <= `POPT_DOUT_RESET;
      o_obj_rdata   <= `POPT_ZERO32;
      o_obj_ack     <= 1'b0;
      o_obj_error   <= 1'b0;
    end
    else
    begin
      o_obj_ack   <= i_obj_read || i_obj_write;
      o_obj_error <= (i_obj_write && !write_ok) ||
                     (i_obj_read && !i_obj_write && !read_hit);
      if (i_obj_read && !i_obj_write)
        o_obj_rdata <= read_hit ? read_value : `POPT_ZERO32;
      if (i_obj_write && write_ok)
      begin
        case (i_obj_index)
          `POPT_OBJ_OPTION:
          begin
            // Masking here keeps unsupported bits zero for every reader.
            option_word <= i_obj_wdata[15:0] &
              `POPT_OPTION_MASK; // [RULE_01]
          end
          `POPT_OBJ_TARGET:  target <= i_obj_wdata;
          `POPT_OBJ_DIG_OUT: o_digital_out <= i_obj_wdata; // [RULE_16]
          default:           target <= target;
        endcase
      end
    end
  end

endmodule // popt_positioning_io

// ### tb/popt_positioning_io_asserts.sv
// Port checker for the positioning option and I/O map block.
// Bound to popt_positioning_io; it sees only that module's ports.
`timescale 1ns/1ps
module popt_checker
(
  input wire        i_clk,
  input wire        i_reset,
  input wire        i_obj_read,
  input wire        i_obj_write,
  input wire [15:0] i_obj_index,
  input wire [7:0]  i_obj_subindex,
  input wire [31:0] i_obj_wdata,
  input wire [31:0] o_obj_rdata,
  input wire        o_obj_ack,
  input wire        o_obj_error,
  input wire [31:0] i_following_error,
  input wire [31:0] o_abs_target,
  input wire        o_setpoint_strobe,
  input wire [31:0] o_digital_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Decoded requests; a write wins when both strobes are high.
  wire        rq = i_obj_read | i_obj_write;
  wire        rd = i_obj_read & ~i_obj_write & i_obj_subindex == 8'h00;
  wire [15:0] ix = i_obj_index;
  wire        dw = i_obj_write & ix == 16'h60FE & i_obj_subindex == 8'h01;
  a_ack_exact: assert property
    (rq |=> o_obj_ack) else $error("Ack missing after a request.");
  a_ack_alone: assert property
    (!rq |=> !o_obj_ack && !o_obj_error) else $error("Ack without request.");
  a_ferr_read: assert property
    (rd && ix == 16'h60F4 |=> o_obj_rdata == $past(i_following_error))
    else $error("Following error read wrong.");
  a_ro_refused: assert property
    (i_obj_write && (ix == 16'h60F4 || ix == 16'h60FD) |=> o_obj_error)
    else $error("Read-only write accepted.");
  a_din_layout: assert property
    (rd && ix == 16'h60FD |=> o_obj_rdata[31:24] == 8'h00
      && o_obj_rdata[15:3] == 13'h0000) else $error("Input word layout.");
  a_opt_fields: assert property
    (rd && ix == 16'h60F2 |=> o_obj_rdata[31:16] == 16'h0000
      && o_obj_rdata[14:12] == 3'h0 && o_obj_rdata[3:2] == 2'h0)
    else $error("Unsupported option bits read back.");
  a_dout_write: assert property
    (dw |=> o_digital_out == $past(i_obj_wdata)) else $error("Output write.");
  a_dout_hold: assert property
    (!dw |=> $stable(o_digital_out)) else $error("Outputs moved alone.");
  a_strobe_pulse: assert property
    (o_setpoint_strobe |=> !o_setpoint_strobe) else $error("Strobe too long.");
  a_target_cause: assert property
    ($changed(o_abs_target) |-> o_setpoint_strobe)
    else $error("Target changed without strobe.");
endmodule // popt_checker

bind popt_positioning_io popt_checker u_chk
(
  .i_clk(i_clk), .i_reset(i_reset), .i_obj_read(i_obj_read),
  .i_obj_write(i_obj_write), .i_obj_index(i_obj_index),
  .i_obj_subindex(i_obj_subindex), .i_obj_wdata(i_obj_wdata),
  .o_obj_rdata(o_obj_rdata), .o_obj_ack(o_obj_ack),
  .o_obj_error(o_obj_error), .i_following_error(i_following_error),
  .o_abs_target(o_abs_target), .o_setpoint_strobe(o_setpoint_strobe),
  .o_digital_out(o_digital_out)
);

// ### tb/popt_motor_model.sv
// Motor side model: fixed positions, range limits and move completion.
// Assumes the block's setpoint strobe marks the start of each move.
`timescale 1ns/1ps
module popt_motor_model
#(
  parameter REACH = 12
)
(
  input  wire        i_clk,
  input  wire        i_reset,
  input  wire        i_setpoint_strobe,
  output wire [31:0] o_following_error,
  output wire [31:0] o_ramp_position,
  output wire [31:0] o_actual_position,
  output wire [31:0] o_range_min,
  output wire [31:0] o_range_max,
  output wire        o_target_reached
);
  reg [7:0] cnt;
  // Fixed positions keep every expected target easy to derive.
  assign o_following_error = 32'hFFFF_FFF6;
  assign o_ramp_position   = 32'h0000_00FA;
  assign o_actual_position = 32'h0000_0064;
  assign o_range_min       = 32'h0000_0000;
  assign o_range_max       = 32'h0000_03E8;
  // Reached shows for four cycles; a strobe reloads the count, so it falls one cycle after a new move starts.
  assign o_target_reached  = cnt != 8'h00 && cnt <= 8'h04;
  // A move stays pending for REACH cycles: a slow answer on purpose.
  always @(posedge i_clk)
    if (i_reset)
      cnt <= 8'h00;
    else if (i_setpoint_strobe)
      cnt <= 8'(REACH + 4);
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
endmodule // popt_motor_model

// ### tb/popt_positioning_io_tb_top.sv
// Self-checking bench for the positioning option and I/O map block.
// Assumes popt_motor_model drives positions and move completion.
`timescale 1ns/1ps
module popt_positioning_io_tb_top;
  reg         i_clk = 1'b0;
  reg         i_reset = 1'b1;
  reg         i_obj_read = 1'b0;
  reg         i_obj_write = 1'b0;
  reg  [15:0] i_obj_index = 16'h0000;
  reg  [7:0]  i_obj_subindex = 8'h00;
  reg  [31:0] i_obj_wdata = 32'h0000_0000;
  reg  [10:0] pins = 11'h000;
  reg  [31:0] d;
  reg  [31:0] prev;
  integer     num_errors = 0;
  integer     checks = 0;
  integer     k;
  wire [31:0] o_obj_rdata, o_abs_target, o_digital_out, i_following_error;
  wire [31:0] i_ramp_position, i_actual_position, i_range_min, i_range_max;
  wire        o_obj_ack, o_obj_error, o_setpoint_strobe, o_move_negative;
  wire        o_via_limit, o_wrap_enable, i_target_reached;
  // Switch pins and general inputs all come from one bench word.
  wire        i_negative_end_switch = pins[0];
  wire        i_positive_end_switch = pins[1];
  wire        i_homing_switch = pins[2];
  wire [7:0]  i_general_in = pins[10:3];
  // Writes that must be refused: read-only, count entry, unknown.
  localparam [143:0] refused = {16'h60F4, 8'h00, 16'h60FD, 8'h00,
    16'h6041, 8'h00, 16'h60FE, 8'h00, 16'h1234, 8'h00, 16'h60F2, 8'h05};

  popt_positioning_io dut (.*);
  popt_motor_model motor
  (
    .i_clk(i_clk), .i_reset(i_reset), .i_setpoint_strobe(o_setpoint_strobe),
    .o_following_error(i_following_error), .o_range_min(i_range_min),
    .o_ramp_position(i_ramp_position), .o_range_max(i_range_max),
    .o_actual_position(i_actual_position), .o_target_reached(i_target_reached)
  );

  always #4 i_clk = ~i_clk;

  // Count a comparison and report a mismatch at once.
  task chk(input string n, input [31:0] e, input [31:0] g);
    checks = checks + 1;
    if (g !== e)
    begin
      num_errors = num_errors + 1;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One object access; the answer is judged one edge after the request.
  task acc(input w, input [15:0] ix, input [7:0] sx, input [31:0] wd,
           input ee);
    @(posedge i_clk);
    #1;
    {i_obj_write, i_obj_read} = {w, ~w};
    {i_obj_index, i_obj_subindex, i_obj_wdata} = {ix, sx, wd};
    @(posedge i_clk);
    #1;
    {i_obj_write, i_obj_read} = 2'b00;
    d = o_obj_rdata;
    chk("ack", 1, {31'h0, o_obj_ack});
    chk("error", {31'h0, ee}, {31'h0, o_obj_error});
  endtask
  // Bounded wait on the strobe, or on move completion when s is set.
  task wt(input s);
    integer n;
    for (n = 0; (s ? i_target_reached : o_setpoint_strobe) !== 1'b1; n++)
    begin
      if (n == 40)
      begin
        num_errors = num_errors + 1;
        final_report;
      end
      @(posedge i_clk);
      #1;
    end
  endtask
  // Read back the new-setpoint and acknowledge bits.
  task hs(input b);
    acc(0, 16'h6040, 8'h00, 0, 0);
    chk("new_setpoint", {31'h0, b}, {31'h0, d[5]});
    acc(0, 16'h6041, 8'h00, 0, 0);
    chk("setpoint_ack", {31'h0, b}, {31'h0, d[12]});
  endtask
  // Load target, option and control, then check the accepted target.
  task mv(input [15:0] o, input [15:0] c, input [31:0] t, input [31:0] e);
    acc(1, 16'h607A, 8'h00, t, 0);
    acc(1, 16'h60F2, 8'h00, {16'h0000, o}, 0);
    acc(1, 16'h6040, 8'h00, {16'h0000, c}, 0);
    wt(0);
    chk("abs_target", e, o_abs_target);
    prev = e;
  endtask
  // Absolute move with auto clear; v[1] set skips the via check.
  task rot(input [1:0] c, input [31:0] t, input n, input [1:0] v);
    mv({8'h00, c, 6'h20}, 16'h0020, t, t);
    hs(0);
    chk("negative", {31'h0, n}, {31'h0, o_move_negative});
    if (!v[1])
      chk("via_limit", {31'h0, v[0]}, {31'h0, o_via_limit});
    chk("wrap", {31'h0, c == 2'h0}, {31'h0, o_wrap_enable});
  endtask

  // Main sequence: reset, then each group of tests in turn.
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    acc(0, 16'h60F2, 8'h00, 0, 0);
    chk("option", 32'h0000_0001, d);
    acc(0, 16'h60FD, 8'h00, 0, 0);
    chk("inputs", 32'h0000_0000, d);
    acc(0, 16'h60FE, 8'h00, 0, 0);
    chk("out_count", 32'h0000_0001, d);
    $display("test reset values done");
    acc(1, 16'h60F2, 8'h00, 32'hFFFF_FFFF, 0);
    acc(0, 16'h60F2, 8'h00, 0, 0);
    chk("option", 32'h0000_8FF3, d);
    for (k = 0; k < 6; k++)
      acc(1, refused[k*24+8 +: 16], refused[k*24 +: 8], 0, 1);
    pins = 11'h5A5;
    repeat (5) @(posedge i_clk);
    acc(0, 16'h60FD, 8'h00, 0, 0);
    chk("inputs", 32'h00B4_0005, d);
    acc(0, 16'h60F4, 8'h00, 0, 0);
    chk("follow_err", 32'hFFFF_FFF6, d);
    acc(1, 16'h60FE, 8'h01, 32'hA5A5_5A5A, 0);
    chk("out_pins", 32'hA5A5_5A5A, o_digital_out);
    $display("test object access done");
    mv(16'h0021, 16'h0020, 32'h0000_0064, 32'h0000_0064);
    hs(0);
    mv(16'h0010, 16'h0020, 32'h0000_00C8, 32'h0000_00C8);
    hs(1);
    wt(1);
    hs(0);
    for (k = 0; k < 2; k++)
    begin
      mv({10'h000, k[0], k[0], 4'h0}, 16'h0020, 32'h0000_0064,
         32'h0000_0064);
      hs(1);
      acc(1, 16'h6040, 8'h00, 0, 0);
      hs(0);
    end
    for (k = 0; k < 4; k++)
      mv({14'h0008, k[1:0]}, 16'h0060, 32'h0000_000A, 32'h0000_000A +
        (k == 1 ? 32'h0000_00FA : k == 2 ? 32'h0000_0064 : prev));
    $display("test setpoint handshake done");
    rot(2'h0, 32'h0000_0032, 1'b1, 2'h2);
    rot(2'h1, 32'h0000_012C, 1'b1, 2'h1);
    rot(2'h1, 32'h0000_0032, 1'b1, 2'h0);
    rot(2'h2, 32'h0000_0032, 1'b0, 2'h1);
    rot(2'h2, 32'h0000_012C, 1'b0, 2'h0);
    rot(2'h3, 32'h0000_012C, 1'b0, 2'h2);
    rot(2'h3, 32'h0000_0384, 1'b1, 2'h2);
    $display("test rotary direction done");
    final_report;
  end
endmodule // popt_positioning_io_tb_top
